// ### design/isd_pkg.sv
// shared constants and types for the iso split descriptor block
package isd_pkg;
  // register byte offsets
  localparam logic [7:0] REG_DESC_W0 = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  // descriptor word zero field positions
  localparam int EP_LSB_BIT = 31;
  localparam int SPLIT_LEN_MSB = 28;
  localparam int SPLIT_LEN_LSB = 18;
  localparam int BYTE_CNT_MSB = 17;
  localparam int BYTE_CNT_LSB = 3;
  localparam int ACTIVE_BIT = 0;
  // writable bits of word zero: 31, 28..18, 17..3, 0
  localparam logic [31:0] DESC_WMASK = 32'h9fff_fff9;
  localparam logic [31:0] DESC_RESET = 32'h0000_0000;
  // status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_REMAIN_LSB = 16;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [0:0]
  {
    ISD_IDLE = 1'b0,
    ISD_RUN = 1'b1
  } isd_state_t;

  typedef enum logic [1:0]
  {
    ISD_SEL_DESC = 2'b00,
    ISD_SEL_DATA = 2'b01,
    ISD_SEL_STATUS = 2'b10,
    ISD_SEL_NONE = 2'b11
  } isd_sel_t;
endpackage : isd_pkg

// ### design/isd_fifo.sv
// synchronous valid/ready fifo holding payload bytes
`timescale 1ns/100ps
module isd_fifo
#(
  parameter int WIDTH = isd_pkg::FIFO_WIDTH,
  parameter int DEPTH = isd_pkg::FIFO_DEPTH
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_valid_i,
  output logic s_ready_o,
  input wire logic [WIDTH-1:0] s_data_i,
  output logic m_valid_o,
  input wire logic m_ready_i,
  output logic [WIDTH-1:0] m_data_o,
  output logic [$clog2(DEPTH+1)-1:0] level_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_param
    $error("isd_fifo: depth must be a power of two of at least 2");
  end

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [LW-1:0] cnt;
  } isd_fifo_state_t;

  isd_fifo_state_t q;
  isd_fifo_state_t next_q;
  logic push;
  logic pop;

  assign s_ready_o = (q.cnt != LW'(DEPTH));
  assign m_valid_o = (q.cnt != '0);
  assign m_data_o = q.mem[q.rd];
  assign level_o = q.cnt;

  always_comb
  begin
    next_q = q;
    push = s_valid_i && s_ready_o;
    pop = m_valid_o && m_ready_i;
    if (push)
    begin
      next_q.mem[q.wr] = s_data_i;
      next_q.wr = q.wr + 1'b1;
    end
    if (pop)
    begin
      next_q.rd = q.rd + 1'b1;
    end
    if (push && !pop)
    begin
      next_q.cnt = q.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_q.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end
endmodule : isd_fifo

// ### design/isd_engine.sv
// iso split descriptor word zero: register, executor and payload path
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
module isd_engine
#(
  parameter int DEPTH = isd_pkg::FIFO_DEPTH
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] endpoint_hi_i,
  input wire logic fatal_err_i,
  output logic [3:0] endpoint_number_o,
  output logic [14:0] max_packet_size_o,
  output logic [7:0] link_data_o,
  output logic link_valid_o,
  output logic link_split_end_o,
  input wire logic link_ready_i
);
  localparam int LW = $clog2(DEPTH+1);

  if (DEPTH < 2 || DEPTH > 128)
  begin : g_bad_param
    $error("isd_engine: fifo depth out of range");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed
  {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] desc;
    isd_pkg::isd_state_t st;
    logic [14:0] remain;
    logic [10:0] chunk;
    logic [3:0] ep;
    logic [14:0] mps;
    logic [7:0] odata;
    logic ovalid;
    logic oend;
  } isd_engine_state_t;

  isd_engine_state_t q;
  isd_engine_state_t next_q;

  function automatic isd_pkg::isd_sel_t reg_decode(input logic [7:0] adr);
    unique case (adr)
      isd_pkg::REG_DESC_W0: reg_decode = isd_pkg::ISD_SEL_DESC;
      isd_pkg::REG_DATA: reg_decode = isd_pkg::ISD_SEL_DATA;
      isd_pkg::REG_STATUS: reg_decode = isd_pkg::ISD_SEL_STATUS;
      default: reg_decode = isd_pkg::ISD_SEL_NONE;
    endcase
  endfunction : reg_decode

  logic fifo_s_valid;
  logic fifo_s_ready;
  logic fifo_m_valid;
  logic fifo_m_ready;
  logic [7:0] fifo_m_data;
  logic [LW-1:0] fifo_level;

  // ****************************************
  // payload fifo
  // ****************************************
  isd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .s_valid_i(fifo_s_valid),
    .s_ready_o(fifo_s_ready),
    .s_data_i(wb_dat_i[7:0]),
    .m_valid_o(fifo_m_valid),
    .m_ready_i(fifo_m_ready),
    .m_data_o(fifo_m_data),
    .level_o(fifo_level)
  );

  logic req;
  logic data_wr;
  logic [10:0] split_len;
  logic [14:0] byte_cnt;
  logic out_free;
  logic [31:0] wmask;

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign data_wr = req && wb_we_i && wb_sel_i[0]
    && (reg_decode(wb_adr_i) == isd_pkg::ISD_SEL_DATA);
  // data writes wait while the fifo is full
  assign fifo_s_valid = data_wr;
  assign split_len = q.desc[isd_pkg::SPLIT_LEN_MSB:isd_pkg::SPLIT_LEN_LSB];
  assign byte_cnt = q.desc[isd_pkg::BYTE_CNT_MSB:isd_pkg::BYTE_CNT_LSB];
  assign out_free = !q.ovalid || link_ready_i;
  assign fifo_m_ready = (q.st == isd_pkg::ISD_RUN) && out_free && (q.remain != '0);
  assign wmask = isd_pkg::DESC_WMASK
    & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_q = q;
    next_q.ack = 1'b0;
    next_q.ep = {endpoint_hi_i, q.desc[isd_pkg::EP_LSB_BIT]};
    if (q.ovalid && link_ready_i)
    begin
      next_q.ovalid = 1'b0;
      next_q.oend = 1'b0;
    end
    // ---- executor
    unique case (q.st)
      isd_pkg::ISD_IDLE:
      begin
        if (q.desc[isd_pkg::ACTIVE_BIT])
        begin
          if (byte_cnt == '0)
          begin
            next_q.desc[isd_pkg::ACTIVE_BIT] = 1'b0;
          end
          else
          begin
            next_q.st = isd_pkg::ISD_RUN;
            next_q.remain = byte_cnt;
            next_q.chunk = '0;
            next_q.mps = byte_cnt;
          end
        end
      end
      isd_pkg::ISD_RUN:
      begin
        if (fifo_m_ready && fifo_m_valid)
        begin
          next_q.odata = fifo_m_data;
          next_q.ovalid = 1'b1;
          next_q.remain = q.remain - 15'h0001;
          // a start split closes at the split length or at the last byte
          if (q.remain == 15'h0001 || (split_len != '0 && q.chunk + 11'h001 == split_len))
          begin
            next_q.oend = 1'b1;
            next_q.chunk = '0;
          end
          else
          begin
            next_q.oend = 1'b0;
            next_q.chunk = q.chunk + 11'h001;
          end
          if (q.remain == 15'h0001)
          begin
            next_q.st = isd_pkg::ISD_IDLE;
            next_q.desc[isd_pkg::ACTIVE_BIT] = 1'b0;
          end
        end
      end
    endcase
    if (fatal_err_i)
    begin
      next_q.st = isd_pkg::ISD_IDLE;
      next_q.remain = '0;
      next_q.desc[isd_pkg::ACTIVE_BIT] = 1'b0;
    end
    // ---- bus slave; a software write wins over the engine's clear
    if (req)
    begin
      unique case (reg_decode(wb_adr_i))
        isd_pkg::ISD_SEL_DESC:
        begin
          next_q.ack = 1'b1;
          next_q.rdata = q.desc;
          if (wb_we_i)
          begin
            next_q.desc = (q.desc & ~wmask) | (wb_dat_i & wmask);
          end
        end
        isd_pkg::ISD_SEL_DATA:
        begin
          next_q.ack = !data_wr || fifo_s_ready;
          next_q.rdata = '0;
        end
        isd_pkg::ISD_SEL_STATUS:
        begin
          next_q.ack = 1'b1;
          next_q.rdata = '0;
          next_q.rdata[isd_pkg::ST_BUSY_BIT] = (q.st == isd_pkg::ISD_RUN);
          next_q.rdata[isd_pkg::ST_LEVEL_LSB +: 8] = 8'(fifo_level);
          next_q.rdata[isd_pkg::ST_REMAIN_LSB +: 15] = q.remain;
        end
        isd_pkg::ISD_SEL_NONE:
        begin
          next_q.ack = 1'b1;
          next_q.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.desc <= isd_pkg::DESC_RESET;
      q.st <= isd_pkg::ISD_IDLE;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign endpoint_number_o = q.ep;
  assign max_packet_size_o = q.mps;
  assign link_data_o = q.odata;
  assign link_valid_o = q.ovalid;
  assign link_split_end_o = q.oend;
endmodule : isd_engine

// ### dv/isd_engine_asserts.sv
// port assertions for the iso split descriptor engine
`timescale 1ns/100ps
module isd_engine_asserts
#(
  parameter int DEPTH = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [2:0] endpoint_hi_i,
  input wire logic [3:0] endpoint_number_o,
  input wire logic [7:0] link_data_o,
  input wire logic link_valid_o,
  input wire logic link_split_end_o,
  input wire logic link_ready_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  wire rd = wb_ack_o && !wb_we_i;
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_time;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !(wb_we_i && wb_adr_i == isd_pkg::REG_DATA)
      |=> wb_ack_o;
  endproperty
  a_ack_time: assert property (p_ack_time) else $error("ack late");
  property p_unmapped;
    rd && !(wb_adr_i inside {8'h00, 8'h04, 8'h08}) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_data_rd;
    rd && wb_adr_i == isd_pkg::REG_DATA |-> wb_dat_o == 32'h0;
  endproperty
  a_data_rd: assert property (p_data_rd) else $error("data read not zero");
  property p_resv;
    rd && wb_adr_i == isd_pkg::REG_DESC_W0 |-> (wb_dat_o & ~isd_pkg::DESC_WMASK) == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_ep0;
    rd && wb_adr_i == isd_pkg::REG_DESC_W0 |-> wb_dat_o[31] == endpoint_number_o[0];
  endproperty
  a_ep0: assert property (p_ep0) else $error("endpoint bit 0 wrong");
  property p_ep_hi;
    !$past(rst_i) |-> endpoint_number_o[3:1] == $past(endpoint_hi_i);
  endproperty
  a_ep_hi: assert property (p_ep_hi) else $error("endpoint high bits wrong");
  property p_hold;
    link_valid_o && !link_ready_i
      |=> link_valid_o && $stable(link_data_o) && $stable(link_split_end_o);
  endproperty
  a_hold: assert property (p_hold) else $error("link byte not held");
endmodule : isd_engine_asserts
bind isd_engine isd_engine_asserts #(.DEPTH(DEPTH)) u_chk (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .endpoint_hi_i, .endpoint_number_o,
  .link_data_o, .link_valid_o, .link_split_end_o, .link_ready_i);

// ### dv/isd_sink.sv
// link sink standing in for the downstream full-speed device
`timescale 1ns/100ps
module isd_sink
(
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic end_i,
  input wire logic stall_i,
  output logic ready_o
);
  logic [8:0] got[$];
  initial ready_o = 1'b0;
  always @(posedge clk_i)
  begin
    if (valid_i && ready_o)
      got.push_back({end_i, data_i});
    ready_o <= !stall_i && ($urandom % 4 != 0);
  end
endmodule : isd_sink

// ### dv/isd_engine_test.sv
// self-checking bench for the iso split descriptor engine
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module isd_engine_test;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic fatal_err_i = 1'b0, stall = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [2:0] endpoint_hi_i = 3'h0;
  logic wb_ack_o, link_valid_o, link_split_end_o, link_ready_i;
  logic [3:0] endpoint_number_o;
  logic [14:0] max_packet_size_o;
  logic [7:0] link_data_o;
  logic [7:0] bytes[$];
  int n_fail = 0;
  int compares = 0;
  isd_engine dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .endpoint_hi_i, .fatal_err_i, .endpoint_number_o,
    .max_packet_size_o, .link_data_o, .link_valid_o, .link_split_end_o, .link_ready_i);
  isd_sink sink (.clk_i, .valid_i(link_valid_o), .data_i(link_data_o),
    .end_i(link_split_end_o), .stall_i(stall), .ready_o(link_ready_i));
  always #4 clk_i = ~clk_i;
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  task automatic push(input int i);
    logic [31:0] q;
    bus(1'b1, isd_pkg::REG_DATA, {24'h0, bytes[i]}, 4'h1, q);
  endtask : push
  task automatic xfer(input int n, input int sp);
    logic [31:0] q, dw;
    int pre, base, i;
    pre = (n < 16) ? n : 16;
    base = sink.got.size();
    bytes = {};
    endpoint_hi_i <= 3'($urandom);
    dw = {1'($urandom), 2'b00, 11'(sp), 15'(n), 3'b000};
    stall <= 1'b1;
    for (i = 0; i < n; i++) bytes.push_back(8'($urandom));
    for (i = 0; i < pre; i++) push(i);
    bus(1'b0, isd_pkg::REG_STATUS, 32'h0, 4'hf, q);
    `CHK(q[15:8], 8'(pre))
    stall <= 1'b0;
    bus(1'b1, isd_pkg::REG_DESC_W0, dw, 4'hf, q);
    repeat (8) @(posedge clk_i);
    `CHK(sink.got.size(), base)
    stall <= 1'b1;
    bus(1'b1, isd_pkg::REG_DESC_W0, dw | 32'h1, 4'hf, q);
    // sink held off so the fifo fills and data pushes wait for room
    fork
      for (i = pre; i < n; i++) push(i);
      begin
        repeat (40) @(posedge clk_i);
        stall <= 1'b0;
      end
    join
    repeat (400) if (sink.got.size() < base + n) @(posedge clk_i);
    for (i = 0; i < n; i++)
      `CHK(sink.got[base + i], {(sp != 0 && (i + 1) % sp == 0) || i == n - 1, bytes[i]})
    `CHK(max_packet_size_o, 15'(n))
    `CHK(endpoint_number_o, {endpoint_hi_i, dw[31]})
    bus(1'b0, isd_pkg::REG_DESC_W0, 32'h0, 4'hf, q);
    `CHK(q, dw)
  endtask : xfer
  initial
  begin
    logic [31:0] q;
    int k;
    void'($urandom(32'h4e43));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, isd_pkg::REG_DESC_W0, 32'h0, 4'hf, q);
    `CHK(q, isd_pkg::DESC_RESET)
    bus(1'b1, isd_pkg::REG_DESC_W0, 32'hffff_fffe, 4'hf, q);
    bus(1'b1, isd_pkg::REG_DESC_W0, 32'h0, 4'h1, q);
    bus(1'b0, isd_pkg::REG_DESC_W0, 32'h0, 4'hf, q);
    `CHK(q, 32'h9fff_ff00)
    `CHK(endpoint_number_o[0], 1'b1)
    bus(1'b1, isd_pkg::REG_DESC_W0, 32'h0, 4'hf, q);
    bus(1'b1, 8'h0c, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, 8'h0c, 32'h0, 4'hf, q);
    `CHK(q, 32'h0)
    bus(1'b1, isd_pkg::REG_DATA, 32'h0000_00a5, 4'he, q);
    bus(1'b0, isd_pkg::REG_DATA, 32'h0, 4'hf, q);
    `CHK(q, 32'h0)
    bus(1'b0, isd_pkg::REG_STATUS, 32'h0, 4'hf, q);
    `CHK(q, 32'h0)
    xfer(5, 5);
    xfer(200, 188);
    xfer(1023, 192);
    repeat (4)
    begin
      k = 1 + $urandom % 16;
      xfer(k, k);
    end
    bytes = {8'h11, 8'h22, 8'h33};
    k = sink.got.size() + 3;
    bus(1'b1, isd_pkg::REG_DESC_W0, 32'h0028_0051, 4'hf, q);
    for (int i = 0; i < 3; i++) push(i);
    repeat (100) if (sink.got.size() < k) @(posedge clk_i);
    bus(1'b0, isd_pkg::REG_STATUS, 32'h0, 4'hf, q);
    `CHK(q, 32'h0007_0001)
    fatal_err_i <= 1'b1;
    @(posedge clk_i);
    fatal_err_i <= 1'b0;
    bus(1'b0, isd_pkg::REG_DESC_W0, 32'h0, 4'hf, q);
    `CHK(q, 32'h0028_0050)
    bus(1'b0, isd_pkg::REG_STATUS, 32'h0, 4'hf, q);
    `CHK(q[0], 1'b0)
    bus(1'b1, isd_pkg::REG_DESC_W0, 32'h0028_0001, 4'hf, q);
    bus(1'b0, isd_pkg::REG_DESC_W0, 32'h0, 4'hf, q);
    `CHK(q, 32'h0028_0000)
    give_verdict();
  end
  initial
  begin
    #400000;
    n_fail++;
    give_verdict();
  end
endmodule : isd_engine_test
